/* shared/lsc_pkg.sv */
// Constants, register layout and carrier types of the LIN signal codec
package lsc_pkg;
  localparam int NSLOT = 130;
  localparam int SLOT_W = 8;
  localparam int ADDR_W = 14;

  // Word index inside one slot window of 0x40 bytes
  localparam logic [3:0] W_CTRL = 4'h0;
  localparam logic [3:0] W_MIN = 4'h1;
  localparam logic [3:0] W_MAX = 4'h2;
  localparam logic [3:0] W_SCALE = 4'h3;
  localparam logic [3:0] W_OFFS = 4'h4;
  localparam logic [3:0] W_INIT = 4'h5;
  localparam logic [3:0] W_BYTES_LO = 4'h6;
  localparam logic [3:0] W_BYTES_HI = 4'h7;
  localparam logic [3:0] W_SRC = 4'h8;
  localparam logic [3:0] W_STAT = 4'h9;
  localparam logic [3:0] W_VAL_LO = 4'ha;
  localparam logic [3:0] W_VAL_HI = 4'hb;
  localparam logic [13:0] A_SLOT_END = 14'h2080;
  localparam logic [13:0] A_NODE = 14'h3000;
  localparam logic [13:0] A_SLV = 14'h3004;

  // Control word fields
  localparam int TYPE_LSB = 0;
  localparam int ENC_LSB = 2;
  localparam int SIZE_LSB = 5;
  localparam int ART_LSB = 16;

  // Reset values: size 1 bit, auto-reset 1000 ms, scale 1.0 in Q16.16
  localparam logic [31:0] CTRL_RST = 32'h03e8_0020;
  localparam logic [27:0] MIN_RST = 28'h0000000;
  localparam logic [27:0] MAX_RST = 28'h0000001;
  localparam logic [31:0] SCALE_RST = 32'h0001_0000;
  localparam logic [31:0] OFFS_RST = 32'h0000_0000;
  localparam logic [15:0] INIT_RST = 16'h0000;
  localparam logic [63:0] BYTES_RST = 64'h0;
  localparam logic [7:0] SRC_RST = 8'h00;
  localparam logic [1:0] NODE_RST = 2'h0;
  localparam logic [63:0] DISC_SAT = 64'h0000_0000_ffff_ffff;
  localparam logic [63:0] ASCII_MASK = 64'h0000_0000_0000_00ff;

  // Encoding, slot type and node type codes
  localparam logic [2:0] ENC_UNDEF = 3'h0;
  localparam logic [2:0] ENC_LOGIC = 3'h1;
  localparam logic [2:0] ENC_PHYS = 3'h2;
  localparam logic [2:0] ENC_BCD = 3'h3;
  localparam logic [2:0] ENC_ASCII = 3'h4;
  localparam logic [1:0] ST_SCALAR = 2'h1;
  localparam logic [1:0] ST_BYTES = 2'h2;
  localparam logic [1:0] NODE_SLAVE = 2'h2;

  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;

  // Internal signal: cont=1 continuous Q48.16 signed, else discrete
  typedef struct packed {
    logic defined;
    logic cont;
    logic [63:0] val;
  } lsc_sig_t;

  typedef struct packed {
    logic valid;
    logic [SLOT_W-1:0] slot;
    lsc_sig_t sig;
  } lsc_evt_t;

  typedef struct packed {
    logic valid;
    logic [SLOT_W-1:0] slot;
    logic [63:0] code;
  } lsc_rx_t;

  typedef struct packed {
    logic valid;
    logic [SLOT_W-1:0] slot;
  } lsc_txq_t;

  typedef struct packed {
    logic valid;
    logic send;
    logic [SLOT_W-1:0] slot;
    logic [63:0] code;
  } lsc_txr_t;

  typedef struct packed {
    logic defined;
    logic state;
  } lsc_slv_t;
endpackage : lsc_pkg

/* core/lsc_codec.sv */
// LIN signal codec: 130 slot encode/decode, auto-reset and slave status
// Notes on behaviour
// - 130 slots, one input one output each
// - transmit value from selectable source, unconnected allowed
// - received output undefined after auto-reset time
// - encoding fixes discrete or continuous kind
// - limits 28-bit, defaults 0 and 1
// - scalar initial value 16 bits, default zero
// - eight initial bytes, default zero
// - logical receive only inside min..max
// - BCD receive passed unchanged
// - ASCII receive keeps low byte
// - physical receive code times scale plus offset
// - outputs undefined after start-up
// - logical transmit only inside min..max
// - BCD transmit unchanged
// - ASCII transmit keeps low byte
// - physical transmit clamped to min..max
// - undefined input sends initial value
// - slave status output from response state
// - master mode leaves status undefined
// - continuous to discrete truncates, saturates
// - negative continuous becomes zero
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lsc_codec #(
  parameter int CYC_PER_MS = lsc_pkg::CYC_PER_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire lsc_pkg::lsc_rx_t rx_in,
  output lsc_pkg::lsc_evt_t sig_out,
  input wire lsc_pkg::lsc_txq_t tx_req,
  output logic [7:0] src_sel,
  input wire lsc_pkg::lsc_sig_t src_val,
  output lsc_pkg::lsc_txr_t tx_out,
  input wire logic resp_state,
  output lsc_pkg::lsc_slv_t slv_out
);

  // Inclusive range test against the slot limits
  function automatic logic in_range(input logic [63:0] c, input logic [27:0] lo, input logic [27:0] hi);
    in_range = (c >= {36'h0, lo}) && (c <= {36'h0, hi});
  endfunction : in_range

  // Continuous Q48.16 to discrete: truncate, negative to zero, saturate
  function automatic logic [63:0] to_disc(input logic [63:0] v);
    logic [63:0] ip;
    ip = {16'h0, v[63:16]};
    if (v[63]) begin
      to_disc = 64'h0;
    end else if (ip > lsc_pkg::DISC_SAT) begin
      to_disc = lsc_pkg::DISC_SAT;
    end else begin
      to_disc = ip;
    end
  endfunction : to_disc

  // Per-slot configuration and state
  logic [31:0] ctrl_mem [lsc_pkg::NSLOT];
  logic [27:0] min_mem [lsc_pkg::NSLOT];
  logic [27:0] max_mem [lsc_pkg::NSLOT];
  logic [31:0] scale_mem [lsc_pkg::NSLOT];
  logic [31:0] offs_mem [lsc_pkg::NSLOT];
  logic [15:0] init_mem [lsc_pkg::NSLOT];
  logic [63:0] bytes_mem [lsc_pkg::NSLOT];
  logic [7:0] src_mem [lsc_pkg::NSLOT];
  lsc_pkg::lsc_sig_t out_mem [lsc_pkg::NSLOT];
  logic [15:0] age_mem [lsc_pkg::NSLOT];
  logic [1:0] node_reg;

  // APB decode
  logic [7:0] a_slot;
  logic [3:0] a_word;
  logic a_in_slot;
  logic wr_en;
  logic [31:0] rd_next;
  logic err_next;
  assign a_slot = paddr[13:6];
  assign a_word = paddr[5:2];
  assign a_in_slot = (paddr < lsc_pkg::A_SLOT_END);
  assign wr_en = psel && penable && pready && pwrite && !pslverr;

  // Read mux and unmapped detection, evaluated in the setup cycle
  always_comb begin
    rd_next = 32'h0;
    err_next = 1'b0;
    if (a_in_slot) begin
      unique case (a_word)
        lsc_pkg::W_CTRL: rd_next = ctrl_mem[a_slot];
        lsc_pkg::W_MIN: rd_next = {4'h0, min_mem[a_slot]};
        lsc_pkg::W_MAX: rd_next = {4'h0, max_mem[a_slot]};
        lsc_pkg::W_SCALE: rd_next = scale_mem[a_slot];
        lsc_pkg::W_OFFS: rd_next = offs_mem[a_slot];
        lsc_pkg::W_INIT: rd_next = {16'h0, init_mem[a_slot]};
        lsc_pkg::W_BYTES_LO: rd_next = bytes_mem[a_slot][31:0];
        lsc_pkg::W_BYTES_HI: rd_next = bytes_mem[a_slot][63:32];
        lsc_pkg::W_SRC: rd_next = {24'h0, src_mem[a_slot]};
        lsc_pkg::W_STAT: rd_next = {age_mem[a_slot], 14'h0, out_mem[a_slot].cont, out_mem[a_slot].defined};
        lsc_pkg::W_VAL_LO: rd_next = out_mem[a_slot].val[31:0];
        lsc_pkg::W_VAL_HI: rd_next = out_mem[a_slot].val[63:32];
        default: err_next = 1'b1;
      endcase
    end else if (paddr == lsc_pkg::A_NODE) begin
      rd_next = {30'h0, node_reg};
    end else if (paddr == lsc_pkg::A_SLV) begin
      rd_next = {30'h0, slv_out.state, slv_out.defined};
    end else begin
      err_next = 1'b1;
    end
  end

  // One wait-free access cycle: answer registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0 : rd_next;
      pready <= 1'b1;
      pslverr <= err_next;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Configuration writes; limits and initial values keep their widths
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < lsc_pkg::NSLOT; i++) begin
        ctrl_mem[i] <= lsc_pkg::CTRL_RST;
        min_mem[i] <= lsc_pkg::MIN_RST;
        max_mem[i] <= lsc_pkg::MAX_RST;
        scale_mem[i] <= lsc_pkg::SCALE_RST;
        offs_mem[i] <= lsc_pkg::OFFS_RST;
        init_mem[i] <= lsc_pkg::INIT_RST;
        bytes_mem[i] <= lsc_pkg::BYTES_RST;
        src_mem[i] <= lsc_pkg::SRC_RST;
      end
      node_reg <= lsc_pkg::NODE_RST;
    end else if (wr_en && a_in_slot) begin
      unique case (a_word)
        lsc_pkg::W_CTRL: ctrl_mem[a_slot] <= pwdata;
        lsc_pkg::W_MIN: min_mem[a_slot] <= pwdata[27:0];
        lsc_pkg::W_MAX: max_mem[a_slot] <= pwdata[27:0];
        lsc_pkg::W_SCALE: scale_mem[a_slot] <= pwdata;
        lsc_pkg::W_OFFS: offs_mem[a_slot] <= pwdata;
        lsc_pkg::W_INIT: init_mem[a_slot] <= pwdata[15:0];
        lsc_pkg::W_BYTES_LO: bytes_mem[a_slot][31:0] <= pwdata;
        lsc_pkg::W_BYTES_HI: bytes_mem[a_slot][63:32] <= pwdata;
        lsc_pkg::W_SRC: src_mem[a_slot] <= pwdata[7:0];
        default: ;
      endcase
    end else if (wr_en && paddr == lsc_pkg::A_NODE) begin
      node_reg <= pwdata[1:0];
    end
  end

  // Receive decode of the slot named by the incoming code
  logic [2:0] rx_enc;
  logic rx_ok;
  lsc_pkg::lsc_sig_t rx_sig;
  logic signed [63:0] rx_prod;
  logic [7:0] rx_idx;
  // A slot number past the tables looks up slot 0; such a code is refused anyway
  assign rx_idx = (32'(rx_in.slot) < lsc_pkg::NSLOT) ? rx_in.slot : 8'h00;
  assign rx_enc = ctrl_mem[rx_idx][lsc_pkg::ENC_LSB +: 3];

  always_comb begin
    rx_prod = $signed({36'h0, rx_in.code[27:0]}) * $signed(scale_mem[rx_idx]);
    rx_ok = 1'b0;
    rx_sig = '{defined: 1'b1, cont: 1'b0, val: rx_in.code};
    unique case (rx_enc)
      lsc_pkg::ENC_LOGIC: begin
        rx_ok = in_range(rx_in.code, min_mem[rx_idx], max_mem[rx_idx]);
      end
      lsc_pkg::ENC_BCD: begin
        rx_ok = 1'b1;
      end
      lsc_pkg::ENC_ASCII: begin
        rx_ok = 1'b1;
        rx_sig.val = rx_in.code & lsc_pkg::ASCII_MASK;
      end
      lsc_pkg::ENC_PHYS: begin
        rx_ok = in_range(rx_in.code, min_mem[rx_idx], max_mem[rx_idx]);
        rx_sig.cont = 1'b1;
        rx_sig.val = 64'(rx_prod + 64'($signed(offs_mem[rx_idx])));
      end
      default: rx_ok = 1'b0;
    endcase
    rx_ok = rx_ok && rx_in.valid && (32'(rx_in.slot) < lsc_pkg::NSLOT);
  end

  // Millisecond tick and the sweep that ages every defined slot once per tick
  logic [31:0] ms_cnt_reg;
  logic sweep_reg;
  logic [7:0] sw_idx_reg;
  logic [15:0] sw_art;
  logic [15:0] sw_age;
  assign sw_art = ctrl_mem[sw_idx_reg][lsc_pkg::ART_LSB +: 16];
  assign sw_age = age_mem[sw_idx_reg] + 16'h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_reg <= 32'h0;
    end else if (ms_cnt_reg == 32'(CYC_PER_MS - 1)) begin
      ms_cnt_reg <= 32'h0;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 32'h1;
    end
  end

  // Sweep pauses while a receive update owns the slot state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sweep_reg <= 1'b0;
      sw_idx_reg <= 8'h00;
    end else if (ms_cnt_reg == 32'(CYC_PER_MS - 1)) begin
      sweep_reg <= 1'b1;
      sw_idx_reg <= 8'h00;
    end else if (sweep_reg && !rx_ok) begin
      sweep_reg <= (32'(sw_idx_reg) != lsc_pkg::NSLOT - 1);
      sw_idx_reg <= sw_idx_reg + 8'h01;
    end
  end

  // Slot outputs: receive updates win, then auto-reset of aged slots
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < lsc_pkg::NSLOT; i++) begin
        out_mem[i] <= '0;
        age_mem[i] <= 16'h0;
      end
      sig_out <= '0;
    end else if (rx_ok) begin
      out_mem[rx_in.slot] <= rx_sig;
      age_mem[rx_in.slot] <= 16'h0;
      sig_out <= '{valid: 1'b1, slot: rx_in.slot, sig: rx_sig};
    end else if (sweep_reg && out_mem[sw_idx_reg].defined) begin
      if (sw_art != 16'h0 && sw_age >= sw_art) begin
        out_mem[sw_idx_reg].defined <= 1'b0;
        sig_out <= '{valid: 1'b1, slot: sw_idx_reg, sig: '0};
      end else begin
        age_mem[sw_idx_reg] <= sw_age;
        sig_out.valid <= 1'b0;
      end
    end else begin
      sig_out.valid <= 1'b0;
    end
  end

  // Transmit stage 1: look up the slot's source so the network can answer
  logic tx1_v_reg;
  logic [7:0] tx1_slot_reg;
  logic tx_req_ok;
  // A refused slot number is replaced by slot 0 so no table is read past its end
  assign tx_req_ok = (32'(tx_req.slot) < lsc_pkg::NSLOT);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx1_v_reg <= 1'b0;
      tx1_slot_reg <= 8'h00;
      src_sel <= 8'h00;
    end else begin
      tx1_v_reg <= tx_req.valid && tx_req_ok;
      tx1_slot_reg <= tx_req_ok ? tx_req.slot : 8'h00;
      if (tx_req_ok) begin
        src_sel <= src_mem[tx_req.slot];
      end else begin
        src_sel <= 8'h00;
      end
    end
  end

  // Transmit stage 2: encode the sampled source value into a code
  logic [31:0] t_ctrl;
  logic [2:0] t_enc;
  logic [27:0] t_min;
  logic [27:0] t_max;
  logic [63:0] t_disc;
  logic [63:0] t_cont;
  logic signed [63:0] t_diff;
  logic signed [63:0] t_quo;
  logic [63:0] t_code;
  logic [63:0] t_mask;
  logic t_send;
  logic [6:0] t_size;
  assign t_ctrl = ctrl_mem[tx1_slot_reg];
  assign t_enc = t_ctrl[lsc_pkg::ENC_LSB +: 3];
  assign t_min = min_mem[tx1_slot_reg];
  assign t_max = max_mem[tx1_slot_reg];
  assign t_size = t_ctrl[lsc_pkg::SIZE_LSB +: 7];

  always_comb begin
    t_disc = src_val.cont ? to_disc(src_val.val) : {32'h0, src_val.val[31:0]};
    t_cont = src_val.cont ? src_val.val : {16'h0, src_val.val[31:0], 16'h0};
    t_diff = $signed(t_cont) - 64'($signed(offs_mem[tx1_slot_reg]));
    t_quo = 64'h0;
    t_send = (t_enc != lsc_pkg::ENC_UNDEF);
    t_code = t_disc;
    if (!src_val.defined || src_sel == 8'h00) begin
      if (t_ctrl[lsc_pkg::TYPE_LSB +: 2] == lsc_pkg::ST_BYTES) begin
        t_code = bytes_mem[tx1_slot_reg];
      end else begin
        t_code = {48'h0, init_mem[tx1_slot_reg]};
      end
    end else begin
      unique case (t_enc)
        lsc_pkg::ENC_LOGIC: t_send = in_range(t_disc, t_min, t_max);
        lsc_pkg::ENC_BCD: t_code = t_disc;
        lsc_pkg::ENC_ASCII: t_code = t_disc & lsc_pkg::ASCII_MASK;
        lsc_pkg::ENC_PHYS: begin
          // A zero scale has no quotient; it is taken as a saturated code
          if (scale_mem[tx1_slot_reg] == 32'h0) begin
            t_quo = $signed(lsc_pkg::DISC_SAT);
          end else begin
            t_quo = t_diff / 64'($signed(scale_mem[tx1_slot_reg]));
          end
          if (t_quo < 0) begin
            t_code = 64'h0;
          end else if (t_quo > $signed(lsc_pkg::DISC_SAT)) begin
            t_code = lsc_pkg::DISC_SAT;
          end else begin
            t_code = t_quo;
          end
          if (t_code < {36'h0, t_min}) begin
            t_code = {36'h0, t_min};
          end else if (t_code > {36'h0, t_max}) begin
            t_code = {36'h0, t_max};
          end
        end
        default: t_send = 1'b0;
      endcase
    end
    // Sizes above 64 are treated as 64 bits
    t_mask = (t_size >= 7'd64 || t_size == 7'd0) ? 64'hffff_ffff_ffff_ffff : ~(64'hffff_ffff_ffff_ffff << t_size);
  end

  // Transmit result register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_out <= '0;
    end else begin
      tx_out.valid <= tx1_v_reg;
      tx_out.send <= tx1_v_reg && t_send;
      tx_out.slot <= tx1_slot_reg;
      tx_out.code <= t_code & t_mask;
    end
  end

  // Slave status: defined only on a slave node
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slv_out <= '0;
    end else begin
      slv_out.defined <= (node_reg == lsc_pkg::NODE_SLAVE);
      slv_out.state <= (node_reg == lsc_pkg::NODE_SLAVE) && resp_state;
    end
  end

endmodule : lsc_codec
`default_nettype wire

/* test/lsc_net_model.sv */
// Signal network model answering the codec's source selection
`timescale 1ns/1ps
`default_nettype none
module lsc_net_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] src_sel,
  input wire logic [7:0] net_id,
  input wire lsc_pkg::lsc_sig_t net_val,
  output lsc_pkg::lsc_sig_t src_val
);
  logic [63:0] junk_reg;
  // Unselected sources show a changing pattern, so a stale value is never mistaken for data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) junk_reg <= 64'h0;
    else junk_reg <= ~junk_reg ^ 64'h5a;
  end
  // Source 0 means not connected and is never served
  assign src_val = (src_sel == net_id && net_id != 8'h00) ? net_val : {1'b0, junk_reg[0], junk_reg};
endmodule : lsc_net_model
`default_nettype wire

/* test/lsc_codec_assertions.sv */
// Port-level checks of the LIN signal codec
`timescale 1ns/1ps
`default_nettype none
module lsc_codec_assertions #(
  parameter int CYC_PER_MS = 40000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire lsc_pkg::lsc_rx_t rx_in,
  input wire lsc_pkg::lsc_evt_t sig_out,
  input wire lsc_pkg::lsc_txq_t tx_req,
  input wire logic [7:0] src_sel,
  input wire lsc_pkg::lsc_sig_t src_val,
  input wire lsc_pkg::lsc_txr_t tx_out,
  input wire logic resp_state,
  input wire lsc_pkg::lsc_slv_t slv_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Steps of a bus access and of a transmit request
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_txq;
    tx_req.valid && tx_req.slot < 8'd130;
  endsequence
  sequence s_unmapped;
    s_setup ##0 (paddr >= lsc_pkg::A_SLOT_END && paddr != lsc_pkg::A_NODE && paddr != lsc_pkg::A_SLV);
  endsequence
  a_apb_answer: assert property (s_setup |=> pready ##1 !pready) else $error("bus access length wrong");
  a_beyond_slots: assert property (s_unmapped |=> pslverr && prdata == 32'h0) else $error("no error past slots");
  a_tx_answer: assert property (s_txq |-> ##2 tx_out.valid && tx_out.slot == $past(tx_req.slot, 2))
    else $error("transmit answer missing");
  a_tx_refuse: assert property (tx_req.valid && tx_req.slot >= 8'd130 |-> ##2 !tx_out.valid)
    else $error("bad slot transmitted");
  a_rx_bad_slot: assert property (rx_in.valid && rx_in.slot >= 8'd130 |=> !(sig_out.valid && sig_out.sig.defined))
    else $error("bad slot received");
  a_rx_cause: assert property (sig_out.valid && sig_out.sig.defined |-> $past(rx_in.valid)
    && $past(rx_in.slot) == sig_out.slot) else $error("output defined without code");
  a_slv_follow: assert property (slv_out.defined |-> slv_out.state == $past(resp_state))
    else $error("slave state not following");
  a_reset_quiet: assert property (disable iff (1'b0) !presetn |-> !sig_out.valid && !tx_out.valid
    && !slv_out.defined && !pready) else $error("outputs active in reset");
endmodule : lsc_codec_assertions
bind lsc_codec lsc_codec_assertions #(.CYC_PER_MS(CYC_PER_MS)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_in(rx_in), .sig_out(sig_out), .tx_req(tx_req),
  .src_sel(src_sel), .src_val(src_val), .tx_out(tx_out), .resp_state(resp_state), .slv_out(slv_out));
`default_nettype wire

/* test/test_lin_signal_codec.sv */
// Self-checking bench of the LIN signal codec
`timescale 1ns/1ps
`default_nettype none
module test_lin_signal_codec;
  localparam int MS = 200;
  localparam logic [31:0] SC = 32'h0002_0000;
  localparam logic [31:0] OF = 32'h0001_0000;
  logic pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, resp_state = 1'b0;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'd96734;
  logic pready, pslverr, err, ev;
  logic [7:0] src_sel, net_id = 8'h07;
  logic [63:0] c;
  lsc_pkg::lsc_rx_t rx_in = '0;
  lsc_pkg::lsc_txq_t tx_req = '0;
  lsc_pkg::lsc_sig_t src_val, net_val = '0, gs;
  lsc_pkg::lsc_evt_t sig_out;
  lsc_pkg::lsc_txr_t tx_out, gt;
  lsc_pkg::lsc_slv_t slv_out;
  int error_cnt = 0, compares = 0, cyc = 0, m;
  lsc_codec #(.CYC_PER_MS(MS)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_in(rx_in), .sig_out(sig_out), .tx_req(tx_req), .src_sel(src_sel), .src_val(src_val),
    .tx_out(tx_out), .resp_state(resp_state), .slv_out(slv_out));
  lsc_net_model u_net (.pclk(pclk), .presetn(presetn), .src_sel(src_sel), .net_id(net_id),
    .net_val(net_val), .src_val(src_val));
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  // Cut a hang short
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [13:0] a(input int s, input logic [3:0] w);
    return 14'(s * 64 + w * 4);
  endfunction : a
  function automatic logic [31:0] ctl(input logic [1:0] t, input logic [2:0] e, input int sz, input int ms);
    return {16'(ms), 4'h0, 7'(sz), e, t};
  endfunction : ctl
  // Expected physical code: truncated quotient, then clamped to 5..100, so negatives give 5
  function automatic logic [63:0] ptx(input logic signed [63:0] v);
    logic signed [63:0] q;
    q = (v - 64'sh10000) / 64'sh20000;
    if (q < 5) q = 5;
    if (q > 100) q = 100;
    return q;
  endfunction : ptx
  task automatic chk(input string n, input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, exp, got);
    end
  endtask : chk
  // Bus access; the answer is taken at the edge where pready is seen high
  task automatic apb(input logic w, input logic [13:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rx(input int s, input logic [63:0] code);
    rx_in <= {1'b1, 8'(s), code};
    @(posedge pclk);
    rx_in.valid <= 1'b0;
    #1;
    ev = sig_out.valid;
    gs = sig_out.sig;
    @(posedge pclk);
  endtask : rx
  task automatic tx(input int s, input lsc_pkg::lsc_sig_t v);
    net_val <= v;
    tx_req <= {1'b1, 8'(s)};
    @(posedge pclk);
    tx_req.valid <= 1'b0;
    @(posedge pclk);
    #1;
    gt = tx_out;
    @(posedge pclk);
  endtask : tx
  task automatic end_sim();
    if (error_cnt == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    // A real falling edge so the asynchronous reset branch runs
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, field widths and the end of the slot space
    apb(0, a(129, lsc_pkg::W_CTRL), 0); chk("ctrl", rd, ctl(0, 0, 1, 1000));
    apb(0, a(129, lsc_pkg::W_MAX), 0); chk("max", rd, 1);
    apb(0, a(129, lsc_pkg::W_INIT), 0); chk("init", rd, 0);
    apb(0, a(129, lsc_pkg::W_BYTES_HI), 0); chk("bytes", rd, 0);
    apb(0, a(129, lsc_pkg::W_STAT), 0); chk("defined", rd[0], 0);
    apb(0, a(130, 0), 0); chk("unmapped", {err, rd}, 33'h100000000);
    apb(1, a(5, lsc_pkg::W_MAX), 32'hffffffff); apb(0, a(5, lsc_pkg::W_MAX), 0); chk("max w", rd, 32'h0fffffff);
    apb(1, a(5, lsc_pkg::W_INIT), 32'hffffffff); apb(0, a(5, lsc_pkg::W_INIT), 0); chk("init w", rd, 32'hffff);
    // Slots: 0 logical, 1 BCD, 2 ASCII, 3 physical, 4 unconnected scalar, 6 unconnected bytes
    apb(1, a(0, 0), ctl(1, lsc_pkg::ENC_LOGIC, 8, 4)); apb(1, a(0, 1), 5); apb(1, a(0, 2), 9);
    apb(1, a(1, 0), ctl(1, lsc_pkg::ENC_BCD, 32, 1000));
    apb(1, a(2, 0), ctl(1, lsc_pkg::ENC_ASCII, 16, 1000));
    apb(1, a(3, 0), ctl(1, lsc_pkg::ENC_PHYS, 16, 1000)); apb(1, a(3, 1), 5); apb(1, a(3, 2), 100);
    apb(1, a(3, 3), SC); apb(1, a(3, 4), OF);
    apb(1, a(4, 0), ctl(1, lsc_pkg::ENC_LOGIC, 8, 0)); apb(1, a(4, 5), 32'hab);
    apb(1, a(6, 0), ctl(2, lsc_pkg::ENC_BCD, 64, 0));
    apb(1, a(6, 6), 32'h44332211); apb(1, a(6, 7), 32'h88776655);
    for (int s = 0; s < 4; s++) apb(1, a(s, lsc_pkg::W_SRC), 32'(net_id));
    // Reception, boundaries of the limits and random codes
    for (int v = 4; v <= 10; v++) begin
      rx(0, 64'(v)); chk("lg ev", ev, v >= 5 && v <= 9);
      if (ev) chk("lg val", {gs.cont, gs.val}, 65'(v));
      rx(3, 64'(v * 16 - 60)); chk("ph ev", ev, (v * 16 - 60) inside {[5:100]});
      if (ev) chk("ph val", {gs.cont, gs.val}, {1'b1, 64'((v * 16 - 60) * SC + OF)});
    end
    repeat (6) begin
      c = {xs(), xs()};
      rx(1, c); chk("bcd", gs.val, c);
      rx(2, c); chk("ascii", gs.val, c & 64'hff);
      rx(7, c); chk("undef enc", ev, 0);
      rx(130, c); chk("bad rx", ev && gs.defined, 0);
    end
    // Transmission of the logical, BCD, ASCII and physical encodings
    for (int v = 4; v <= 10; v++) begin
      tx(0, {2'b10, 64'(v)}); chk("lg send", gt.send, v >= 5 && v <= 9);
      if (gt.send) chk("lg code", gt.code, 64'(v));
    end
    repeat (6) begin
      c = 64'(xs());
      tx(1, {2'b10, c}); chk("bcd tx", {gt.valid, gt.send, gt.code}, {2'b11, c});
      tx(2, {2'b10, c}); chk("ascii tx", gt.code, c & 64'hff);
    end
    c = 64'sh15_0000; tx(3, {2'b11, c}); chk("ph tx", gt.code, ptx(c));
    c = 64'sh7fff_0000_0000_0000; tx(3, {2'b11, c}); chk("ph max", gt.code, ptx(c));
    c = -64'sh30000; tx(3, {2'b11, c}); chk("ph neg", gt.code, ptx(c));
    tx(4, {2'b10, 64'h5}); chk("init", gt.code, 64'hab);
    tx(6, {2'b10, 64'h5}); chk("bytes tx", gt.code, 64'h8877665544332211);
    tx(130, {2'b10, 64'h5}); chk("bad tx", gt.valid, 0);
    // Auto-reset 3..4 ms after the update, whatever the tick phase; a restart at 2.5 ms would push it past 5 ms
    rx(0, 7);
    repeat (5 * MS / 2) @(posedge pclk);
    rx(0, 200);
    m = 5 * MS / 2 + 2;
    while (!(sig_out.valid && sig_out.slot == 0 && !sig_out.sig.defined) && m < 1500) begin
      @(posedge pclk); #1; m++;
    end
    chk("art", m >= 3 * MS && m <= 4 * MS + 10, 1);
    @(posedge pclk);
    // Slave status in slave mode, then master mode
    apb(1, lsc_pkg::A_NODE, 2);
    repeat (6) begin
      resp_state <= xs() >> 31;
      repeat (2) @(posedge pclk);
      #1; chk("slave", slv_out, {1'b1, resp_state});
      @(posedge pclk);
    end
    apb(1, lsc_pkg::A_NODE, 1);
    #1; chk("master", slv_out.defined, 0);
    end_sim();
  end
endmodule : test_lin_signal_codec
`default_nettype wire
